// *** clamp_coast_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module clamp_coast_ctrl (
  // Clock and reset
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  // AXI4-Lite write
  input  wire logic [clamp_coast_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  // AXI4-Lite read
  input  wire logic [clamp_coast_pkg::AXI_AW-1:0] araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [31:0]                            rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  // Video timing inputs
  input  wire logic                              hsync_in,
  input  wire logic                              restore_in,
  input  wire logic                              holdover_in,
  // Front-end control outputs
  output logic                                   clamp_active,
  output logic                                   clock_hold,
  output logic                                   line_ref_pulse
);

  localparam logic [7:0] ONE8 = 8'h01;

  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx == clamp_coast_pkg::IDX_SYNC_CTL) || (idx == clamp_coast_pkg::IDX_CLAMP_CTL)
          || (idx == clamp_coast_pkg::IDX_CLAMP_PLACE) || (idx == clamp_coast_pkg::IDX_CLAMP_DUR)
          || (idx == clamp_coast_pkg::IDX_STATUS);
  endfunction

  function automatic logic [7:0] addr_idx(input logic [clamp_coast_pkg::AXI_AW-1:0] a);
    addr_idx = a[clamp_coast_pkg::ADDR_LSB +: clamp_coast_pkg::IDX_W];
  endfunction

  // Synchronised inputs
  logic [2:0] sync_q;
  logic       hs_s;
  logic       rst_s;
  logic       hold_s;

  input_sync #(.W(clamp_coast_pkg::SYNC_W)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({hsync_in, restore_in, holdover_in}),
    .sync_out (sync_q)
  );

  assign hs_s   = sync_q[2];
  assign rst_s  = sync_q[1];
  assign hold_s = sync_q[0];

  // Configuration registers
  logic [7:0] sync_ctl;
  logic [7:0] clamp_ctl;
  logic [7:0] place;
  logic [7:0] dur;
  logic       ext_sel;
  logic       coast_pol;
  logic       hs_act;
  logic       restore_act;
  logic       coast_act;

  assign ext_sel     = clamp_ctl[clamp_coast_pkg::BIT_EXT_CLAMP];
  assign coast_pol   = clamp_ctl[clamp_coast_pkg::BIT_COAST_POL];
  assign hs_act      = sync_ctl[clamp_coast_pkg::BIT_HS_POL] ? hs_s : ~hs_s;
  assign restore_act = clamp_ctl[clamp_coast_pkg::BIT_CLAMP_POL] ? rst_s : ~rst_s;
  assign coast_act   = coast_pol ? hold_s : ~hold_s;

  // Bus slave state
  logic       aw_got;
  logic       w_got;
  logic [7:0] aw_idx;
  logic [7:0] w_byte;
  logic       w_lane0;
  logic       next_aw_got;
  logic       next_w_got;
  logic [7:0] next_aw_idx;
  logic [7:0] next_w_byte;
  logic       next_w_lane0;
  logic       next_awready;
  logic       next_wready;
  logic       next_bvalid;
  logic [1:0] next_bresp;
  logic       next_arready;
  logic       next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [7:0] next_sync_ctl;
  logic [7:0] next_clamp_ctl;
  logic [7:0] next_place;
  logic [7:0] next_dur;
  logic [7:0] status;
  logic [7:0] rd_idx;

  always_comb begin
    status = 8'h00;
    status[clamp_coast_pkg::ST_CLAMP] = clamp_active;
    status[clamp_coast_pkg::ST_HOLD]  = clock_hold;
    status[clamp_coast_pkg::ST_HSYNC] = hs_act;
    next_aw_got    = aw_got;
    next_w_got     = w_got;
    next_aw_idx    = aw_idx;
    next_w_byte    = w_byte;
    next_w_lane0   = w_lane0;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_rvalid    = rvalid;
    next_rdata     = rdata;
    next_rresp     = rresp;
    next_sync_ctl  = sync_ctl;
    next_clamp_ctl = clamp_ctl;
    next_place     = place;
    next_dur       = dur;
    rd_idx         = addr_idx(araddr);
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_got && w_got && !bvalid) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = mapped(aw_idx) ? clamp_coast_pkg::RESP_OKAY : clamp_coast_pkg::RESP_SLVERR;
      if (w_lane0) begin
        unique case (aw_idx)
          clamp_coast_pkg::IDX_SYNC_CTL:    next_sync_ctl  = w_byte;
          clamp_coast_pkg::IDX_CLAMP_CTL:   next_clamp_ctl = w_byte;
          clamp_coast_pkg::IDX_CLAMP_PLACE: next_place     = w_byte;
          clamp_coast_pkg::IDX_CLAMP_DUR:   next_dur       = w_byte;
          default: ;
        endcase
      end
    end
    if (awvalid && awready) begin
      next_aw_got = 1'b1;
      next_aw_idx = addr_idx(awaddr);
    end
    if (wvalid && wready) begin
      next_w_got   = 1'b1;
      next_w_byte  = wdata[clamp_coast_pkg::REG_W-1:0];
      next_w_lane0 = wstrb[0];
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(rd_idx) ? clamp_coast_pkg::RESP_OKAY : clamp_coast_pkg::RESP_SLVERR;
      unique case (rd_idx)
        clamp_coast_pkg::IDX_SYNC_CTL:    next_rdata = {24'h000000, sync_ctl};
        clamp_coast_pkg::IDX_CLAMP_CTL:   next_rdata = {24'h000000, clamp_ctl};
        clamp_coast_pkg::IDX_CLAMP_PLACE: next_rdata = {24'h000000, place};
        clamp_coast_pkg::IDX_CLAMP_DUR:   next_rdata = {24'h000000, dur};
        clamp_coast_pkg::IDX_STATUS:      next_rdata = {24'h000000, status};
        default:                          next_rdata = 32'h00000000;
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_idx    <= 8'h00;
      w_byte    <= 8'h00;
      w_lane0   <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= clamp_coast_pkg::RESP_OKAY;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rdata     <= 32'h00000000;
      rresp     <= clamp_coast_pkg::RESP_OKAY;
      sync_ctl  <= clamp_coast_pkg::RST_SYNC_CTL;
      clamp_ctl <= clamp_coast_pkg::RST_CLAMP_CTL;
      place     <= clamp_coast_pkg::RST_CLAMP_PLACE;
      dur       <= clamp_coast_pkg::RST_CLAMP_DUR;
    end else begin
      aw_got    <= next_aw_got;
      w_got     <= next_w_got;
      aw_idx    <= next_aw_idx;
      w_byte    <= next_w_byte;
      w_lane0   <= next_w_lane0;
      awready   <= next_awready;
      wready    <= next_wready;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      arready   <= next_arready;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
      sync_ctl  <= next_sync_ctl;
      clamp_ctl <= next_clamp_ctl;
      place     <= next_place;
      dur       <= next_dur;
    end
  end

  // Restore timer and outputs
  clamp_coast_pkg::timer_state_t state;
  clamp_coast_pkg::timer_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       hs_prev;
  logic       lead;
  logic       trail;
  logic       next_clamp_active;
  // Edges armed once synchroniser and hs_prev hold real samples
  logic [clamp_coast_pkg::SYNC_W-1:0] warm;
  logic [clamp_coast_pkg::SYNC_W-1:0] next_warm;

  assign lead  = hs_act && !hs_prev && warm[clamp_coast_pkg::SYNC_W-1];
  assign trail = !hs_act && hs_prev && warm[clamp_coast_pkg::SYNC_W-1];

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_warm  = {warm[clamp_coast_pkg::SYNC_W-2:0], 1'b1};
    unique case (state)
      clamp_coast_pkg::T_IDLE: ;
      clamp_coast_pkg::T_DELAY: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - ONE8;
        end else if (dur != 8'h00) begin
          next_state = clamp_coast_pkg::T_CLAMP;
          next_cnt   = dur - ONE8;
        end else begin
          next_state = clamp_coast_pkg::T_IDLE;
        end
      end
      clamp_coast_pkg::T_CLAMP: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - ONE8;
        end else begin
          next_state = clamp_coast_pkg::T_IDLE;
        end
      end
    endcase
    if (trail) begin
      next_state = clamp_coast_pkg::T_DELAY;
      next_cnt   = place;
    end
    if (ext_sel) begin
      next_clamp_active = restore_act;
    end else begin
      next_clamp_active = (next_state == clamp_coast_pkg::T_CLAMP);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state          <= clamp_coast_pkg::T_IDLE;
      cnt            <= 8'h00;
      hs_prev        <= 1'b0;
      warm           <= '0;
      clamp_active   <= 1'b0;
      clock_hold     <= 1'b0;
      line_ref_pulse <= 1'b0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      hs_prev        <= hs_act;
      warm           <= next_warm;
      clamp_active   <= next_clamp_active;
      clock_hold     <= coast_act;
      line_ref_pulse <= lead && !coast_act;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ext_clamp_follow: assert property ($past(ext_sel) && ext_sel |-> clamp_active == $past(restore_act))
    else $error("external clamp does not follow restore input");
  a_ext_select_gate: assert property (!$past(ext_sel) |-> clamp_active == (state == clamp_coast_pkg::T_CLAMP))
    else $error("restore input used while not selected");
  a_reset_defaults: assert property ($past(!aresetn) |-> !ext_sel && coast_pol)
    else $error("wrong control defaults after reset");
  a_timer_start: assert property (trail |=> state == clamp_coast_pkg::T_DELAY && cnt == $past(place))
    else $error("restore timer not started at sync trailing edge");
  a_clamp_end: assert property (state == clamp_coast_pkg::T_CLAMP && cnt == 8'h00 && !trail
                                |=> state == clamp_coast_pkg::T_IDLE)
    else $error("restore interval overran duration");
  a_restore_sense: assert property (ext_sel && $past(ext_sel, 3) && $past(clamp_ctl[clamp_coast_pkg::BIT_CLAMP_POL], 3)
                                    && clamp_ctl[clamp_coast_pkg::BIT_CLAMP_POL]
                                    |-> clamp_active == $past(restore_in, 3))
    else $error("restore sense not applied after synchroniser");
  a_hold_no_track: assert property (clock_hold |-> !line_ref_pulse)
    else $error("sync reference passed during holdover");
  a_hold_sense: assert property (!coast_pol && $past(!coast_pol, 2) |-> clock_hold == !$past(holdover_in, 3))
    else $error("holdover sense not applied");
  a_lead_only: assert property (line_ref_pulse |-> $past(hs_act) && !$past(hs_prev))
    else $error("reference pulse not on leading edge");
  a_sync_delay: assert property (coast_pol && $past(coast_pol, 2) && $past(aresetn, 3)
                                 |-> clock_hold == $past(holdover_in, 3))
    else $error("holdover not delayed by synchroniser");

  c_ext_clamp: cover property (ext_sel && $rose(clamp_active));
  c_int_clamp: cover property (!ext_sel && state == clamp_coast_pkg::T_CLAMP ##1 state == clamp_coast_pkg::T_IDLE);
  c_holdover:  cover property ($rose(clock_hold));
  c_bus_write: cover property (bvalid && bready && bresp == clamp_coast_pkg::RESP_OKAY);

endmodule
`default_nettype wire

// *** clamp_coast_input_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module clamp_coast_input_control_tb;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    logic [1:0]  resp;
  } row_t;
  localparam row_t ROWS [8] = '{
    '{12'h048, 32'hffffffff, 32'h00000000, 2'h0}, '{12'h000, 32'h0000005a, 32'h00000000, 2'h2},
    '{12'h040, 32'h123456ff, 32'h000000ff, 2'h0}, '{12'h044, 32'h000000a5, 32'h000000a5, 2'h0},
    '{12'h038, 32'h00000040, 32'h00000040, 2'h0}, '{12'h038, 32'h00000000, 32'h00000000, 2'h0},
    '{12'h03c, 32'h00000048, 32'h00000048, 2'h0}, '{12'h03c, 32'h00000008, 32'h00000008, 2'h0}};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        hsync_in, restore_in, holdover_in, clamp_active, clock_hold, line_ref_pulse;
  logic        line_go, hsync_pol, restore_pol, ext_used, hold_req, hold_pol, clamp_q;
  int          failures = 0, check_count = 0, cyc = 0, clamp_cnt = 0, pulse_cnt = 0;
  int          rise_cyc, pulse_cyc, go_cyc, dc, dp, c0, p0, r0, q0;

  clamp_coast_ctrl u_clamp_coast_ctrl (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .hsync_in(hsync_in),
    .restore_in(restore_in), .holdover_in(holdover_in), .clamp_active(clamp_active),
    .clock_hold(clock_hold), .line_ref_pulse(line_ref_pulse));

  video_timing_model u_video_timing_model (
    .aclk(aclk), .aresetn(aresetn), .line_go(line_go), .hsync_pol(hsync_pol),
    .restore_pol(restore_pol), .ext_used(ext_used), .hold_req(hold_req), .hold_pol(hold_pol),
    .hsync_out(hsync_in), .restore_out(restore_in), .holdover_out(holdover_in));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    clamp_cnt <= clamp_cnt + int'(clamp_active);
    pulse_cnt <= pulse_cnt + int'(line_ref_pulse);
    if (clamp_active && !clamp_q) rise_cyc <= cyc;
    if (line_ref_pulse) pulse_cyc <= cyc;
    clamp_q <= clamp_active;
    if (cyc == 20000) begin
      failures++;
      final_report;
    end
  end

  function automatic logic [11:0] addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask

  task axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  task set(input logic [7:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axi_write(addr(idx), d, r);
  endtask

  task do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task run_line;
    @(negedge aclk);
    c0 = clamp_cnt;
    p0 = pulse_cnt;
    @(posedge aclk);
    line_go <= 1'b1;
    go_cyc = cyc;
    @(posedge aclk);
    line_go <= 1'b0;
    repeat (60) @(posedge aclk);
    @(negedge aclk);
    dc = clamp_cnt - c0;
    dp = pulse_cnt - p0;
  endtask

  task final_report;
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, line_go} = '0;
    {hsync_pol, restore_pol, ext_used, hold_req, clamp_q} = '0;
    hold_pol = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    do_reset;
    for (int i = 0; i < 4; i++) begin
      axi_read(addr(clamp_coast_pkg::IDX_SYNC_CTL + 8'(i)), rv, rs);
      check(rv, (i == 1) ? 32'h00000008 : 32'h00000000);
    end
    foreach (ROWS[i]) begin
      axi_write(ROWS[i].a, ROWS[i].d, rs);
      check(32'(rs), 32'(ROWS[i].resp));
      axi_read(ROWS[i].a, rv, rs);
      check(rv, ROWS[i].rd);
      check(32'(rs), 32'(ROWS[i].resp));
    end
    // Write with lane 0 off is answered but not stored
    wstrb <= 4'h0;
    axi_write(addr(clamp_coast_pkg::IDX_CLAMP_PLACE), 32'h0000005a, rs);
    wstrb <= 4'h1;
    check(32'(rs), 32'(clamp_coast_pkg::RESP_OKAY));
    axi_read(addr(clamp_coast_pkg::IDX_CLAMP_PLACE), rv, rs);
    check(rv, 32'h000000ff);
    // Internal timer, external restore pulses present but ignored
    set(clamp_coast_pkg::IDX_CLAMP_DUR, 32'h00000005);
    set(clamp_coast_pkg::IDX_CLAMP_PLACE, 32'h00000000);
    ext_used <= 1'b1;
    restore_pol <= 1'b1;
    run_line;
    check(dc, 32'h00000005);
    check(dp, 32'h00000001);
    r0 = rise_cyc - go_cyc;
    q0 = pulse_cyc - go_cyc;
    set(clamp_coast_pkg::IDX_CLAMP_PLACE, 32'h0000000a);
    run_line;
    check(rise_cyc - go_cyc, r0 + 10);
    set(clamp_coast_pkg::IDX_CLAMP_DUR, 32'h00000000);
    run_line;
    check(dc, 32'h00000000);
    // External restore in both senses
    set(clamp_coast_pkg::IDX_CLAMP_DUR, 32'h00000005);
    for (int p = 0; p < 2; p++) begin
      set(clamp_coast_pkg::IDX_CLAMP_CTL, 32'h00000008);
      restore_pol <= p[0];
      set(clamp_coast_pkg::IDX_CLAMP_CTL, p[0] ? 32'h000000c8 : 32'h00000088);
      run_line;
      check(dc, 32'h00000007);
    end
    set(clamp_coast_pkg::IDX_CLAMP_CTL, 32'h00000008);
    ext_used <= 1'b0;
    // Holdover in both senses
    hold_req <= 1'b1;
    repeat (6) @(posedge aclk);
    check(clock_hold, 32'h00000001);
    axi_read(addr(clamp_coast_pkg::IDX_STATUS), rv, rs);
    check(rv, 32'h00000001 << clamp_coast_pkg::ST_HOLD);
    run_line;
    check(dp, 32'h00000000);
    hold_req <= 1'b0;
    repeat (6) @(posedge aclk);
    check(clock_hold, 32'h00000000);
    set(clamp_coast_pkg::IDX_CLAMP_CTL, 32'h00000000);
    hold_pol <= 1'b0;
    repeat (6) @(posedge aclk);
    check(clock_hold, 32'h00000000);
    hold_req <= 1'b1;
    repeat (6) @(posedge aclk);
    check(clock_hold, 32'h00000001);
    hold_req <= 1'b0;
    // Rising leading edge of line sync
    set(clamp_coast_pkg::IDX_SYNC_CTL, 32'h00000040);
    hsync_pol <= 1'b1;
    repeat (6) @(posedge aclk);
    run_line;
    check(dp, 32'h00000001);
    check(pulse_cyc - go_cyc, q0);
    // Second reset in mid-run
    do_reset;
    axi_read(addr(clamp_coast_pkg::IDX_CLAMP_CTL), rv, rs);
    check(rv, 32'h00000008);
    axi_read(addr(clamp_coast_pkg::IDX_SYNC_CTL), rv, rs);
    check(rv, 32'h00000000);
    final_report;
  end
endmodule
`default_nettype wire

// *** clamp_coast_pkg.sv ***
package clamp_coast_pkg;

  // Bus geometry
  localparam int          AXI_AW      = 12;
  localparam int          ADDR_LSB    = 2;
  localparam int          IDX_W       = 8;
  localparam int          REG_W       = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_SYNC_CTL    = 8'h0e;
  localparam logic [7:0]  IDX_CLAMP_CTL   = 8'h0f;
  localparam logic [7:0]  IDX_CLAMP_PLACE = 8'h10;
  localparam logic [7:0]  IDX_CLAMP_DUR   = 8'h11;
  localparam logic [7:0]  IDX_STATUS      = 8'h12;

  // Field positions
  localparam int          BIT_HS_POL    = 6;
  localparam int          BIT_EXT_CLAMP = 7;
  localparam int          BIT_CLAMP_POL = 6;
  localparam int          BIT_COAST_POL = 3;
  localparam int          ST_CLAMP      = 0;
  localparam int          ST_HOLD       = 1;
  localparam int          ST_HSYNC      = 2;

  // Reset values
  localparam logic [7:0]  RST_SYNC_CTL    = 8'h00;
  localparam logic [7:0]  RST_CLAMP_CTL   = 8'h08;
  localparam logic [7:0]  RST_CLAMP_PLACE = 8'h00;
  localparam logic [7:0]  RST_CLAMP_DUR   = 8'h00;

  // Responses
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // Synchroniser input count, also the edge warm-up cycles
  localparam int          SYNC_W = 3;

  typedef enum logic [1:0] {T_IDLE, T_DELAY, T_CLAMP} timer_state_t;

endpackage

// *** input_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Asynchronous levels in, clean levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule
`default_nettype wire

// *** video_timing_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_timing_model #(
  parameter int SYNC_LEN    = 6,
  parameter int PORCH       = 2,
  parameter int RESTORE_LEN = 7
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Scenario controls
  input  wire logic line_go,
  input  wire logic hsync_pol,
  input  wire logic restore_pol,
  input  wire logic ext_used,
  input  wire logic hold_req,
  input  wire logic hold_pol,
  // Pins toward the device
  output logic      hsync_out,
  output logic      restore_out,
  output logic      holdover_out
);
  int   cnt;
  logic sync_act;
  logic rst_act;
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt <= 0;
    else if (line_go) cnt <= 1;
    else if (cnt != 0) cnt <= (cnt == 60) ? 0 : cnt + 1;
  end
  assign sync_act = (cnt != 0) && (cnt <= SYNC_LEN);
  // Restore only in the back porch
  assign rst_act = (cnt > SYNC_LEN + PORCH) && (cnt <= SYNC_LEN + PORCH + RESTORE_LEN);
  assign hsync_out = hsync_pol ? sync_act : !sync_act;
  // Grounded when unused
  assign restore_out = ext_used ? (restore_pol ? rst_act : !rst_act) : 1'b0;
  // Idle holdover sits at its inactive level
  assign holdover_out = hold_pol ? hold_req : !hold_req;
endmodule
`default_nettype wire
